// ==== core/cie_core.sv ====
module cie_core
  import cie_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  output logic [7:0] acc_a,
  output logic [7:0] acc_b,
  output logic [15:0] index_reg,
  output logic [15:0] stack_ptr,
  output logic [15:0] prog_cnt,
  output logic [5:0] ccr,
  output logic illegal_op
);
  typedef struct packed {
    cie_state_t st;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic [7:0] a;
    logic [7:0] b;
    logic [15:0] x;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [5:0] ccr;
    logic [7:0] op;
    logic [15:0] ea;
    logic [7:0] hi;
    logic [3:0] cnt;
    logic ill;
  } cie_regs_t;

  cie_regs_t r;
  cie_regs_t next_r;
  logic [15:0] alu_b;
  logic [15:0] alu_a;
  logic alu_sub;
  logic [15:0] alu_res;
  logic alu_n;
  logic alu_z;
  logic alu_v;
  logic alu_c;
  logic br_take;
  logic [1:0] mode;
  logic is_mem16;
  logic is_store;
  logic [15:0] word;

  assign mode = r.op[MODE_HI:MODE_LO];
  assign is_mem16 = (r.op == OP_DOUBLE_SUBTRACT_IMM) || (r.op == OP_DOUBLE_SUBTRACT_DIR) || (r.op == OP_DOUBLE_SUBTRACT_IDX)
    || (r.op == OP_DOUBLE_SUBTRACT_EXT) || (r.op == OP_CPX_IMM) || (r.op == OP_CPX_DIR) || (r.op == OP_CPX_IDX)
    || (r.op == OP_CPX_EXT) || (r.op == OP_DOUBLE_ADD_IMM) || (r.op == OP_DOUBLE_ADD_DIR) || (r.op == OP_DOUBLE_ADD_IDX)
    || (r.op == OP_DOUBLE_ADD_EXT);
  assign is_store = (r.op == OP_STD_DIR) || (r.op == OP_STD_IDX) || (r.op == OP_STD_EXT);
  assign word = {r.hi, mem_rdata};

  always_comb begin
    alu_sub = 1'b1;
    alu_a = {r.a, r.b};
    alu_b = word;
    if (r.op == OP_SBA) begin
      alu_a = {r.a, 8'h00};
      alu_b = {r.b, 8'h00};
    end else if ((r.op == OP_CPX_IMM) || (r.op == OP_CPX_DIR) || (r.op == OP_CPX_IDX) || (r.op == OP_CPX_EXT)) begin
      alu_a = r.x;
    end else if ((r.op == OP_DOUBLE_ADD_IMM) || (r.op == OP_DOUBLE_ADD_DIR) || (r.op == OP_DOUBLE_ADD_IDX)
      || (r.op == OP_DOUBLE_ADD_EXT)) begin
      alu_sub = 1'b0;
    end
  end

  cie_alu16 u_alu (
    .opa(alu_a),
    .opb(alu_b),
    .sub(alu_sub),
    .res(alu_res),
    .n(alu_n),
    .z(alu_z),
    .v(alu_v),
    .c(alu_c)
  );

  cie_branch_cond u_br (
    .opcode(r.op),
    .ccr(r.ccr),
    .take(br_take)
  );

  always_comb begin
    next_r = r;
    next_r.wr = 1'b0;
    case (r.st)
      CIE_RST_HI: begin
        next_r.addr = RESET_VECTOR_ADDR + ONE16;
        next_r.st = CIE_RST_LO;
        next_r.hi = mem_rdata;
      end
      CIE_RST_LO: begin
        next_r.pc = {r.hi, mem_rdata};
        next_r.addr = {r.hi, mem_rdata};
        next_r.st = CIE_FETCH;
      end
      CIE_FETCH: begin
        next_r.op = mem_rdata;
        next_r.pc = r.pc + ONE16;
        next_r.addr = r.pc + ONE16;
        next_r.st = CIE_OPER1;
        next_r.cnt = 4'h0;
      end
      CIE_OPER1: begin
        // SBA and NOP complete here, other implied ops move on; byte at addr is read but not consumed
        next_r.st = CIE_FETCH;
        next_r.addr = r.pc;
        case (r.op)
          OP_SBA: begin
            next_r.a = alu_res[15:8];
            next_r.ccr[FL_N] = alu_n;
            next_r.ccr[FL_Z] = (alu_res[15:8] == 8'h00);
            next_r.ccr[FL_V] = alu_v;
            next_r.ccr[FL_C] = alu_c;
          end
          OP_NOP: begin
          end
          OP_DOUBLE_SHIFT_LEFT, OP_DOUBLE_SHIFT_RIGHT_LOGICAL, OP_ABX, OP_TSX, OP_TXS, OP_INS, OP_DES, OP_INDEX_PULL: begin
            next_r.st = CIE_IDLE1;
            next_r.addr = DUMMY_ADDR;
          end
          OP_INDEX_PUSH: begin
            next_r.addr = r.sp;
            next_r.wr = 1'b1;
            next_r.wdata = r.x[7:0];
            next_r.st = CIE_WR_HI;
          end
          OP_MUL: begin
            next_r.st = CIE_WAIT;
            next_r.addr = DUMMY_ADDR;
            next_r.cnt = 4'h2;
          end
          default: begin
            if (r.op[7:4] == OP_BRA[7:4]) begin
              next_r.hi = mem_rdata;
              next_r.pc = r.pc + ONE16;
              next_r.st = CIE_IDLE1;
              next_r.addr = DUMMY_ADDR;
            end else if (is_mem16 || is_store) begin
              next_r.hi = mem_rdata;
              next_r.pc = r.pc + ONE16;
              if (is_mem16 && (mode == MODE_IMM)) begin
                next_r.ea = r.pc + ONE16;
                next_r.addr = r.pc + ONE16;
                next_r.st = CIE_MEM_LO;
              end else if (mode == MODE_DIR) begin
                next_r.ea = {8'h00, mem_rdata};
                next_r.addr = {8'h00, mem_rdata};
                next_r.st = is_store ? CIE_WR_HI : CIE_MEM_HI;
                if (is_store) begin
                  next_r.wr = 1'b1;
                  next_r.wdata = r.a;
                end
              end else if (mode == MODE_IDX) begin
                next_r.ea = r.x + {8'h00, mem_rdata};
                next_r.addr = DUMMY_ADDR;
                next_r.st = CIE_IDLE1;
              end else begin
                next_r.addr = r.pc + ONE16;
                next_r.st = CIE_OPER2;
              end
            end else begin
              next_r.ill = 1'b1;
            end
          end
        endcase
      end
      CIE_OPER2: begin
        next_r.ea = {r.hi, mem_rdata};
        next_r.addr = {r.hi, mem_rdata};
        next_r.pc = r.pc + ONE16;
        next_r.st = is_store ? CIE_WR_HI : CIE_MEM_HI;
        if (is_store) begin
          next_r.wr = 1'b1;
          next_r.wdata = r.a;
        end
      end
      CIE_IDLE1: begin
        next_r.st = CIE_FETCH;
        next_r.addr = r.pc;
        if (r.op[7:4] == OP_BRA[7:4]) begin
          if (br_take) begin
            next_r.pc = r.pc + {{8{r.hi[7]}}, r.hi};
            next_r.addr = r.pc + {{8{r.hi[7]}}, r.hi};
          end
        end else if (is_mem16 || is_store) begin
          next_r.addr = r.ea;
          next_r.st = is_store ? CIE_WR_HI : CIE_MEM_HI;
          if (is_store) begin
            next_r.wr = 1'b1;
            next_r.wdata = r.a;
          end
        end else begin
          case (r.op)
            OP_DOUBLE_SHIFT_LEFT: begin
              next_r.a = {r.a[6:0], r.b[7]};
              next_r.b = {r.b[6:0], 1'b0};
              next_r.ccr[FL_C] = r.a[7];
              next_r.ccr[FL_N] = r.a[6];
              next_r.ccr[FL_Z] = ({r.a[6:0], r.b} == 15'h0000);
              next_r.ccr[FL_V] = r.a[6] ^ r.a[7];
            end
            OP_DOUBLE_SHIFT_RIGHT_LOGICAL: begin
              next_r.a = {1'b0, r.a[7:1]};
              next_r.b = {r.a[0], r.b[7:1]};
              next_r.ccr[FL_C] = r.b[0];
              next_r.ccr[FL_N] = 1'b0;
              next_r.ccr[FL_Z] = ({r.a, r.b[7:1]} == 15'h0000);
              next_r.ccr[FL_V] = r.b[0];
            end
            OP_ABX: next_r.x = r.x + {8'h00, r.b};
            OP_TSX: next_r.x = r.sp + ONE16;
            OP_TXS: next_r.sp = r.x - ONE16;
            OP_INS: next_r.sp = r.sp + ONE16;
            OP_DES: next_r.sp = r.sp - ONE16;
            OP_INDEX_PULL: begin
              next_r.addr = r.sp + ONE16;
              next_r.st = CIE_MEM_HI;
            end
            default: begin
            end
          endcase
        end
      end
      CIE_MEM_HI: begin
        next_r.hi = mem_rdata;
        next_r.addr = r.addr + ONE16;
        next_r.st = CIE_MEM_LO;
      end
      CIE_MEM_LO: begin
        next_r.addr = DUMMY_ADDR;
        next_r.st = CIE_WAIT;
        next_r.cnt = 4'h0;
        if (r.op == OP_INDEX_PULL) begin
          next_r.x = word;
          next_r.sp = r.sp + TWO16;
          next_r.st = CIE_FETCH;
          next_r.addr = r.pc;
        end else begin
          if (mode == MODE_IMM) begin
            next_r.pc = r.pc + ONE16;
          end
          if ((r.op != OP_CPX_IMM) && (r.op != OP_CPX_DIR) && (r.op != OP_CPX_IDX) && (r.op != OP_CPX_EXT)) begin
            next_r.a = alu_res[15:8];
            next_r.b = alu_res[7:0];
          end
          next_r.ccr[FL_N] = alu_n;
          next_r.ccr[FL_Z] = alu_z;
          next_r.ccr[FL_V] = alu_v;
          next_r.ccr[FL_C] = alu_c;
        end
      end
      CIE_WAIT: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.op != OP_MUL || r.cnt == 4'(MUL_CYCLES - 1)) begin
          next_r.st = CIE_FETCH;
          next_r.addr = r.pc;
          if (r.op == OP_MUL) begin
            {next_r.a, next_r.b} = r.a * r.b;
            next_r.ccr[FL_C] = next_r.b[7];
          end
        end
      end
      CIE_WR_HI: begin
        next_r.wr = 1'b1;
        if (r.op == OP_INDEX_PUSH) begin
          next_r.addr = r.sp - ONE16;
          next_r.wdata = r.x[15:8];
        end else begin
          next_r.addr = r.addr + ONE16;
          next_r.wdata = r.b;
        end
        next_r.st = CIE_WR_LO;
      end
      CIE_WR_LO: begin
        next_r.st = CIE_FETCH;
        next_r.addr = r.pc;
        if (r.op == OP_INDEX_PUSH) begin
          next_r.sp = r.sp - TWO16;
        end else begin
          next_r.ccr[FL_N] = r.a[7];
          next_r.ccr[FL_Z] = ({r.a, r.b} == 16'h0000);
          next_r.ccr[FL_V] = 1'b0;
        end
      end
      default: begin
        next_r.st = CIE_RST_HI;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0;
      r.st <= CIE_RST_HI;
      r.addr <= RESET_VECTOR_ADDR;
      r.ccr <= CCR_RESET;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    mem_addr = r.addr;
    mem_wdata = r.wdata;
    mem_wr = r.wr;
    acc_a = r.a;
    acc_b = r.b;
    index_reg = r.x;
    stack_ptr = r.sp;
    prog_cnt = r.pc;
    ccr = r.ccr;
    illegal_op = r.ill;
  end
endmodule : cie_core

// ==== core/cie_pkg.sv ====
package cie_pkg;
  localparam logic [7:0] OP_SBA = 8'h10;
  localparam logic [7:0] OP_DOUBLE_SHIFT_RIGHT_LOGICAL = 8'h04;
  localparam logic [7:0] OP_DOUBLE_SHIFT_LEFT = 8'h05;
  localparam logic [7:0] OP_BRA = 8'h20;
  localparam logic [7:0] OP_BRN = 8'h21;
  localparam logic [7:0] OP_BHI = 8'h22;
  localparam logic [7:0] OP_BLS = 8'h23;
  localparam logic [7:0] OP_BCC = 8'h24;
  localparam logic [7:0] OP_BCS = 8'h25;
  localparam logic [7:0] OP_BNE = 8'h26;
  localparam logic [7:0] OP_BEQ = 8'h27;
  localparam logic [7:0] OP_TSX = 8'h30;
  localparam logic [7:0] OP_INS = 8'h31;
  localparam logic [7:0] OP_DES = 8'h34;
  localparam logic [7:0] OP_TXS = 8'h35;
  localparam logic [7:0] OP_INDEX_PULL = 8'h38;
  localparam logic [7:0] OP_ABX = 8'h3a;
  localparam logic [7:0] OP_INDEX_PUSH = 8'h3c;
  localparam logic [7:0] OP_MUL = 8'h3d;
  localparam logic [7:0] OP_NOP = 8'h01;
  localparam logic [7:0] OP_DOUBLE_SUBTRACT_IMM = 8'h83;
  localparam logic [7:0] OP_DOUBLE_SUBTRACT_DIR = 8'h93;
  localparam logic [7:0] OP_DOUBLE_SUBTRACT_IDX = 8'ha3;
  localparam logic [7:0] OP_DOUBLE_SUBTRACT_EXT = 8'hb3;
  localparam logic [7:0] OP_CPX_IMM = 8'h8c;
  localparam logic [7:0] OP_CPX_DIR = 8'h9c;
  localparam logic [7:0] OP_CPX_IDX = 8'hac;
  localparam logic [7:0] OP_CPX_EXT = 8'hbc;
  localparam logic [7:0] OP_DOUBLE_ADD_IMM = 8'hc3;
  localparam logic [7:0] OP_DOUBLE_ADD_DIR = 8'hd3;
  localparam logic [7:0] OP_DOUBLE_ADD_IDX = 8'he3;
  localparam logic [7:0] OP_DOUBLE_ADD_EXT = 8'hf3;
  localparam logic [7:0] OP_STD_DIR = 8'hdd;
  localparam logic [7:0] OP_STD_IDX = 8'hed;
  localparam logic [7:0] OP_STD_EXT = 8'hfd;
  // Mode field is opcode bits 5:4 for the 16-bit memory group
  localparam int MODE_HI = 5;
  localparam int MODE_LO = 4;
  localparam logic [1:0] MODE_IMM = 2'h0;
  localparam logic [1:0] MODE_DIR = 2'h1;
  localparam logic [1:0] MODE_IDX = 2'h2;
  localparam logic [1:0] MODE_EXT = 2'h3;
  // Condition flag positions
  localparam int FL_C = 0;
  localparam int FL_V = 1;
  localparam int FL_Z = 2;
  localparam int FL_N = 3;
  localparam logic [5:0] CCR_RESET = 6'h10;
  localparam logic [15:0] RESET_VECTOR_ADDR = 16'hfffe;
  localparam logic [15:0] DUMMY_ADDR = 16'hffff;
  localparam logic [15:0] ONE16 = 16'h0001;
  localparam logic [15:0] TWO16 = 16'h0002;
  localparam int MUL_CYCLES = 10;
  typedef enum logic [3:0] {
    CIE_RST_HI = 4'h0,
    CIE_RST_LO = 4'h1,
    CIE_FETCH = 4'h2,
    CIE_OPER1 = 4'h3,
    CIE_OPER2 = 4'h4,
    CIE_IDLE1 = 4'h5,
    CIE_MEM_HI = 4'h6,
    CIE_MEM_LO = 4'h7,
    CIE_WAIT = 4'h8,
    CIE_WR_HI = 4'h9,
    CIE_WR_LO = 4'ha
  } cie_state_t;
endpackage : cie_pkg

// ==== core/cie_alu16.sv ====
module cie_alu16
  import cie_pkg::*;
(
  input wire logic [15:0] opa,
  input wire logic [15:0] opb,
  input wire logic sub,
  output logic [15:0] res,
  output logic n,
  output logic z,
  output logic v,
  output logic c
);
  logic [16:0] sum;
  always_comb begin
    if (sub) begin
      sum = {1'b0, opa} - {1'b0, opb};
    end else begin
      sum = {1'b0, opa} + {1'b0, opb};
    end
    res = sum[15:0];
    n = sum[15];
    z = (sum[15:0] == 16'h0000);
    c = sum[16];
    if (sub) begin
      v = (opa[15] != opb[15]) && (sum[15] != opa[15]);
    end else begin
      v = (opa[15] == opb[15]) && (sum[15] != opa[15]);
    end
  end
endmodule : cie_alu16

// ==== core/cie_branch_cond.sv ====
module cie_branch_cond
  import cie_pkg::*;
(
  input wire logic [7:0] opcode,
  input wire logic [5:0] ccr,
  output logic take
);
  logic c;
  logic z;
  logic n;
  logic v;
  always_comb begin
    c = ccr[FL_C];
    z = ccr[FL_Z];
    n = ccr[FL_N];
    v = ccr[FL_V];
    case (opcode[3:0])
      4'h0: take = 1'b1;
      4'h1: take = 1'b0;
      4'h2: take = ~(c | z);
      4'h3: take = c | z;
      4'h4: take = ~c;
      4'h5: take = c;
      4'h6: take = ~z;
      4'h7: take = z;
      4'h8: take = ~v;
      4'h9: take = v;
      4'ha: take = ~n;
      4'hb: take = n;
      4'hc: take = ~(n ^ v);
      4'hd: take = n ^ v;
      4'he: take = ~(z | (n ^ v));
      default: take = z | (n ^ v);
    endcase
  end
endmodule : cie_branch_cond

// ==== dv/cie_mem_model.sv ====
module cie_mem_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:65535];
  // Answers within the cycle, as the core samples read data at every edge
  assign mem_rdata = mem[mem_addr];
  always @(posedge clk) begin
    if (mem_wr) begin
      mem[mem_addr] <= mem_wdata;
    end
  end
endmodule : cie_mem_model

// ==== dv/cie_core_sva.sv ====
module cie_core_sva
  import cie_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic [7:0] acc_a,
  input wire logic [7:0] acc_b,
  input wire logic [15:0] index_reg,
  input wire logic [15:0] stack_ptr,
  input wire logic [15:0] prog_cnt,
  input wire logic [5:0] ccr,
  input wire logic illegal_op
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  chk_vector_fetch: assert property ($fell(sys_rst) |-> mem_addr == RESET_VECTOR_ADDR && !mem_wr ##[1:2]
    mem_addr == DUMMY_ADDR) else $error("Restart vector not read from the top two bytes");
  chk_reset_regs: assert property ($fell(sys_rst) |-> ccr == CCR_RESET && index_reg == 16'h0000
    && stack_ptr == 16'h0000) else $error("Registers not at reset values");
  chk_write_pair: assert property ($rose(mem_wr) |=> mem_wr ##1 !mem_wr)
    else $error("Write burst is not exactly two bytes");
  chk_pair_data: assert property ($rose(mem_wr) |->
    (mem_wdata == acc_a ##1 mem_wdata == acc_b && mem_addr == $past(mem_addr) + 16'h0001) or
    (mem_wdata == index_reg[7:0] ##1 mem_wdata == index_reg[15:8] && mem_addr == $past(mem_addr) - 16'h0001))
    else $error("Written byte pair has wrong data or address order");
  chk_d_kept: assert property (mem_wr |-> $stable({acc_a, acc_b}))
    else $error("Double accumulator changed during a store");
  chk_x_kept: assert property (mem_wr |-> $stable(index_reg))
    else $error("Index changed during a push");
  chk_index_flags: assert property (!$past(sys_rst) && $changed(index_reg) |-> $stable(ccr))
    else $error("Flags changed with the index register");
  chk_stack_flags: assert property (!$past(sys_rst) && $changed(stack_ptr) |-> $stable(ccr))
    else $error("Flags changed with the stack pointer");
endmodule : cie_core_sva

bind cie_core cie_core_sva cie_core_sva_i (
  .clk(clk), .sys_rst(sys_rst), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_wr(mem_wr), .acc_a(acc_a), .acc_b(acc_b), .index_reg(index_reg), .stack_ptr(stack_ptr),
  .prog_cnt(prog_cnt), .ccr(ccr), .illegal_op(illegal_op)
);

// ==== dv/cie_core_bench.sv ====
module cie_core_bench
  import cie_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  `define CIE_CHECK(act, exp) begin checked++; if ((act) !== (exp)) begin miscompares++; \
    $display("ERROR time %0t got %h expected %h", $time, (act), (exp)); end end
  localparam logic [8:0] BRANCH_MARKS = 9'h125;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] mem_rdata;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_wr;
  logic [7:0] acc_a;
  logic [7:0] acc_b;
  logic [15:0] index_reg;
  logic [15:0] stack_ptr;
  logic [15:0] prog_cnt;
  logic [5:0] ccr;
  logic illegal_op;
  logic [7:0] prog[$];
  int miscompares = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  cie_core cie_core_i (.clk(clk), .sys_rst(sys_rst), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .acc_a(acc_a), .acc_b(acc_b), .index_reg(index_reg),
    .stack_ptr(stack_ptr), .prog_cnt(prog_cnt), .ccr(ccr), .illegal_op(illegal_op));
  cie_mem_model cie_mem_model_i (.clk(clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_wr(mem_wr),
    .mem_rdata(mem_rdata));
  function automatic logic [15:0] word(input logic [15:0] a);
    return {cie_mem_model_i.mem[a], cie_mem_model_i.mem[a + 16'h0001]};
  endfunction : word
  task automatic put(input logic [15:0] a, input logic [15:0] w);
    cie_mem_model_i.mem[a] = w[15:8];
    cie_mem_model_i.mem[a + 16'h0001] = w[7:0];
  endtask : put
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  // Loads the program behind reset, then runs it until it parks in its closing self-loop
  task automatic run_prog(input string name);
    int n;
    logic [15:0] trap;
    @(posedge clk);
    sys_rst <= 1'b1;
    for (int i = 0; i < 65536; i++) begin
      cie_mem_model_i.mem[i] = 8'hff;
    end
    put(16'hfffe, 16'h0100);
    put(16'h0001, 16'h20f0);
    put(16'h0050, 16'h0003);
    put(16'h0052, 16'h0000);
    put(16'h0054, 16'h8000);
    put(16'h0056, 16'h0000);
    foreach (prog[i]) begin
      cie_mem_model_i.mem[16'h0100 + i] = prog[i];
    end
    trap = 16'h0100 + 16'(prog.size()) - 16'h0002;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    n = 0;
    while (mem_addr !== trap && n < 2000) begin
      @(negedge clk);
      n++;
    end
    `CIE_CHECK(mem_addr, trap)
    `CIE_CHECK(prog_cnt, trap)
    repeat (8) @(negedge clk);
    $display("Test %s finished", name);
  endtask : run_prog
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    final_report();
  end
  initial begin
    prog = '{8'hc3, 8'h92, 8'h35, 8'h05, 8'hdd, 8'h10, 8'h04, 8'hed, 8'h05, 8'h38, 8'h3a, 8'h3c, 8'h35,
      8'h34, 8'h34, 8'h31, 8'h30, 8'h3d, 8'hfd, 8'h00, 8'h20, 8'h10, 8'h20, 8'hfe};
    run_prog("data path");
    `CIE_CHECK(word(16'h0010), 16'h246a)
    `CIE_CHECK(word(16'h0005), 16'h1235)
    `CIE_CHECK(word(16'h0001), 16'h2125)
    `CIE_CHECK(word(16'h0020), 16'h03ba)
    `CIE_CHECK(acc_a, 8'h49)
    `CIE_CHECK(index_reg, 16'h2124)
    `CIE_CHECK(stack_ptr, 16'h2123)
    `CIE_CHECK(ccr, 6'h11)
    prog = '{8'hc3, 8'h00, 8'h05, 8'h83, 8'h00, 8'h05, 8'h27, 8'h02, 8'hdd, 8'h30, 8'h26, 8'h02, 8'hdd,
      8'h32, 8'h24, 8'h02, 8'hdd, 8'h34, 8'h25, 8'h02, 8'hdd, 8'h36, 8'h22, 8'h02, 8'hdd, 8'h38, 8'h23,
      8'h02, 8'hdd, 8'h3a, 8'h21, 8'h02, 8'hdd, 8'h3c, 8'h8c, 8'h00, 8'h01, 8'h22, 8'h02, 8'hdd, 8'h3e,
      8'h25, 8'h02, 8'hdd, 8'h40, 8'h93, 8'h50, 8'hdd, 8'h44, 8'h9c, 8'h52, 8'ha3, 8'h54, 8'hdd, 8'h42,
      8'hac, 8'h56, 8'h20, 8'hfe};
    run_prog("branches");
    for (int i = 0; i < 9; i++) `CIE_CHECK(word(16'h0030 + 16'(2 * i)), {16{BRANCH_MARKS[i]}})
    `CIE_CHECK(word(16'h0044), 16'hfffd)
    `CIE_CHECK(word(16'h0042), 16'h7ffd)
    `CIE_CHECK(ccr, 6'h14)
    `CIE_CHECK(illegal_op, 1'b0)
    final_report();
  end
endmodule : cie_core_bench
